// [hw/oss_pkg.sv]
package oss_pkg;

  // ----------------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] CTRL_OFF     = 8'h00;
  localparam logic [7:0] STATUS_OFF   = 8'h04;
  localparam logic [7:0] IRQ_STAT_OFF = 8'h08;
  localparam logic [7:0] IRQ_MASK_OFF = 8'h0c;
  localparam logic [7:0] MAP_LO_OFF   = 8'h10;
  localparam logic [7:0] MAP_HI_OFF   = 8'h14;
  localparam logic [7:0] LAST_OFF     = 8'h18;

  // ----------------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------------
  localparam int          CTRL_ALM_EN_BIT   = 0;
  localparam int          CTRL_ORG_SET_BIT  = 1;
  localparam int          CTRL_ORG_CLR_BIT  = 2;
  localparam logic        ALM_EN_RST        = 1'b0;
  localparam int          IRQ_START_BIT     = 0;
  localparam int          IRQ_ALARM_BIT     = 1;
  localparam logic [1:0]  IRQ_MASK_RST      = 2'h0;
  localparam int          NUM_SHORTCUT      = 6;
  localparam int          MAP_FIELD_W       = 8;
  localparam logic [5:0]  ENTRY_MAX         = 6'h3f;
  localparam logic [5:0]  SEQ_PTR_RST       = 6'h00;
  localparam int          SYNC_STAGES       = 2;

  // ----------------------------------------------------------------------
  // carried types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    SRC_PLAIN    = 3'b001,
    SRC_SEQ      = 3'b010,
    SRC_SHORTCUT = 3'b100
  } oss_src_type;

  typedef struct packed {
    logic        valid;
    oss_src_type src;
    logic [5:0]  entry;
  } oss_start_type;

  function automatic logic [5:0] oss_next_entry(input logic [5:0] e);
    oss_next_entry = (e == ENTRY_MAX) ? 6'h00 : e + 6'h01;
  endfunction : oss_next_entry

endpackage : oss_pkg

// [hw/oss_edge_sync.sv]
`timescale 1ns/1ps
// two-stage synchroniser plus rising edge pulse, one per input bit
module oss_edge_sync #(
  parameter int W = 8
) (
  input  wire logic         sys_clk,   // clock
  input  wire logic         rst_b,     // async reset, active low
  input  wire logic [W-1:0] async_in,  // raw inputs
  output logic      [W-1:0] rise_q     // one-cycle rise pulses
);
  import oss_pkg::*;

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rise_q <= '0;
    end else begin
      rise_q <= s2_q & ~s3_q;
    end
  end

endmodule : oss_edge_sync

// [hw/oss_top.sv]
`timescale 1ns/1ps
// Summary of operation
// - select inputs form entry 0..63, bit0 least significant.
// - plain start launches positioning with currently selected entry.
// - home alarm enable setting, 0 off, 1 on, resets to 0.
// - enabled check alarms when positioning starts without origin set.
// - a sequential trigger starts the next entry, no reselection, unless a plain or shortcut trigger rises in the same cycle.
// - shortcut trigger starts its mapped entry, ignoring select inputs.
// - six mapping settings 0..63, defaults 0 to 5.
module oss_top (
  input  wire logic               sys_clk,            // 100 MHz clock
  input  wire logic               rst_b,              // async reset
  input  wire logic               psel,               // apb select
  input  wire logic               penable,            // apb enable
  input  wire logic               pwrite,             // apb direction
  input  wire logic [7:0]         paddr,              // apb address
  input  wire logic [31:0]        pwdata,             // apb write data
  output logic      [31:0]        prdata,             // apb read data
  output logic                    pready,             // apb ready
  output logic                    pslverr,            // apb error
  input  wire logic               data_select_bit0,   // entry bit 0
  input  wire logic               data_select_bit1,   // entry bit 1
  input  wire logic               data_select_bit2,   // entry bit 2
  input  wire logic               data_select_bit3,   // entry bit 3
  input  wire logic               data_select_bit4,   // entry bit 4
  input  wire logic               data_select_bit5,   // entry bit 5
  input  wire logic               start_trigger,      // plain start
  input  wire logic               sequential_advance_trigger, // next
  input  wire logic               shortcut_trigger_0, // shortcut 0
  input  wire logic               shortcut_trigger_1, // shortcut 1
  input  wire logic               shortcut_trigger_2, // shortcut 2
  input  wire logic               shortcut_trigger_3, // shortcut 3
  input  wire logic               shortcut_trigger_4, // shortcut 4
  input  wire logic               shortcut_trigger_5, // shortcut 5
  input  wire logic               origin_set,         // origin known
  output oss_pkg::oss_start_type  start_cmd_q,        // start pulse
  output logic                    home_alarm_q,       // alarm level
  output logic                    irq_q               // interrupt
);
  import oss_pkg::*;

  // ----------------------------------------------------------------------
  // trigger synchronisation
  // ----------------------------------------------------------------------
  logic [7:0] trig_raw;
  logic [7:0] trig_rise;
  logic [5:0] sel_q;

  assign trig_raw = {shortcut_trigger_5, shortcut_trigger_4,
                     shortcut_trigger_3, shortcut_trigger_2,
                     shortcut_trigger_1, shortcut_trigger_0,
                     sequential_advance_trigger, start_trigger};

  oss_edge_sync #(.W(8)) u_sync (
    .sys_clk  (sys_clk),
    .rst_b    (rst_b),
    .async_in (trig_raw),
    .rise_q   (trig_rise)
  );

  // select inputs pass two stages, one fewer than the triggers, so sel_q is one cycle newer than the trig_rise sample
  logic [5:0] sel_s1_q;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sel_s1_q <= '0;
      sel_q    <= '0;
    end else begin
      sel_s1_q <= {data_select_bit5, data_select_bit4, data_select_bit3,
                   data_select_bit2, data_select_bit1,
                   data_select_bit0};
      sel_q    <= sel_s1_q;
    end
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  logic                    alm_en_q;
  logic                    org_sw_q;
  logic [1:0]              irq_stat_q;
  logic [1:0]              irq_mask_q;
  logic [NUM_SHORTCUT-1:0][5:0] map_q;
  logic [5:0]              seq_ptr_q;
  logic [5:0]              last_entry_q;
  logic                    wr_en;
  logic                    rd_en;
  logic                    origin_ok;

  assign wr_en     = psel && penable && pwrite;
  assign rd_en     = psel && penable && !pwrite;
  assign origin_ok = origin_set || org_sw_q;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      alm_en_q <= ALM_EN_RST;
      org_sw_q <= 1'b0;
    end else if (wr_en && paddr == CTRL_OFF) begin
      alm_en_q <= pwdata[CTRL_ALM_EN_BIT];
      if (pwdata[CTRL_ORG_SET_BIT]) begin
        org_sw_q <= 1'b1;
      end else if (pwdata[CTRL_ORG_CLR_BIT]) begin
        org_sw_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < NUM_SHORTCUT; i++) begin
        map_q[i] <= 6'(i);
      end
    end else if (wr_en && paddr == MAP_LO_OFF) begin
      for (int i = 0; i < 4; i++) begin
        map_q[i] <= pwdata[i*MAP_FIELD_W +: 6];
      end
    end else if (wr_en && paddr == MAP_HI_OFF) begin
      for (int i = 0; i < 2; i++) begin
        map_q[i+4] <= pwdata[i*MAP_FIELD_W +: 6];
      end
    end
  end

  // ----------------------------------------------------------------------
  // start arbitration: any shortcut highest (shortcut 0 before 1..5), then plain, then sequential
  // ----------------------------------------------------------------------
  oss_start_type start_d;
  always_comb begin
    start_d = '{valid: 1'b0, src: SRC_PLAIN, entry: 6'h00};
    if (|trig_rise[7:2]) begin
      start_d.valid = 1'b1;
      start_d.src   = SRC_SHORTCUT;
      for (int i = NUM_SHORTCUT-1; i >= 0; i--) begin
        if (trig_rise[i+2]) begin
          start_d.entry = map_q[i];
        end
      end
    end else if (trig_rise[0]) begin
      start_d.valid = 1'b1;
      start_d.src   = SRC_PLAIN;
      start_d.entry = sel_q;
    end else if (trig_rise[1]) begin
      start_d.valid = 1'b1;
      start_d.src   = SRC_SEQ;
      start_d.entry = seq_ptr_q;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      start_cmd_q <= '{valid: 1'b0, src: SRC_PLAIN, entry: 6'h00};
    end else begin
      start_cmd_q <= start_d;
    end
  end

  // sequential pointer follows whichever entry ran last
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      seq_ptr_q    <= SEQ_PTR_RST;
      last_entry_q <= 6'h00;
    end else if (start_d.valid) begin
      seq_ptr_q    <= oss_next_entry(start_d.entry);
      last_entry_q <= start_d.entry;
    end
  end

  // ----------------------------------------------------------------------
  // home alarm, sticky until origin becomes known
  // ----------------------------------------------------------------------
  logic alarm_evt;
  assign alarm_evt = start_d.valid && alm_en_q && !origin_ok;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      home_alarm_q <= 1'b0;
    end else if (alarm_evt) begin
      home_alarm_q <= 1'b1;
    end else if (origin_ok) begin
      home_alarm_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // interrupts: set wins over write-one-to-clear
  // ----------------------------------------------------------------------
  logic [1:0] irq_set;
  assign irq_set = {alarm_evt, start_d.valid};

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_stat_q <= 2'h0;
    end else begin
      if (wr_en && paddr == IRQ_STAT_OFF) begin
        irq_stat_q <= (irq_stat_q & ~pwdata[1:0]) | irq_set;
      end else begin
        irq_stat_q <= irq_stat_q | irq_set;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_mask_q <= IRQ_MASK_RST;
    end else if (wr_en && paddr == IRQ_MASK_OFF) begin
      irq_mask_q <= pwdata[1:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(irq_stat_q & irq_mask_q);
    end
  end

  // ----------------------------------------------------------------------
  // apb read path, no wait states
  // ----------------------------------------------------------------------
  logic [31:0] rd_d;
  logic        hit;
  always_comb begin
    rd_d = 32'h0;
    hit  = 1'b1;
    unique case (paddr)
      CTRL_OFF:     rd_d = {30'h0, org_sw_q, alm_en_q};
      STATUS_OFF:   rd_d = {12'h0, seq_ptr_q, 6'h00, sel_q,
                            origin_ok, home_alarm_q};
      IRQ_STAT_OFF: rd_d = {30'h0, irq_stat_q};
      IRQ_MASK_OFF: rd_d = {30'h0, irq_mask_q};
      MAP_LO_OFF:   rd_d = {2'h0, map_q[3], 2'h0, map_q[2],
                            2'h0, map_q[1], 2'h0, map_q[0]};
      MAP_HI_OFF:   rd_d = {16'h0, 2'h0, map_q[5], 2'h0, map_q[4]};
      LAST_OFF:     rd_d = {26'h0, last_entry_q};
      default:      hit  = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !hit;
      prdata  <= (psel && !penable && !pwrite) ? rd_d : 32'h0;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  a_alarm_raise: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    alarm_evt |=> home_alarm_q)
    else $error("alarm not raised");
  a_alarm_quiet: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (start_d.valid && !alm_en_q && !$past(home_alarm_q) && !home_alarm_q)
    |=> !home_alarm_q)
    else $error("alarm raised while disabled");
  a_plain_entry: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (trig_rise[0] && !(|trig_rise[7:2])) |=>
    start_cmd_q.valid && start_cmd_q.entry == $past(sel_q))
    else $error("plain start entry wrong");
  a_seq_advance: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (start_cmd_q.valid && start_cmd_q.src == SRC_SEQ) |->
    seq_ptr_q == oss_next_entry(start_cmd_q.entry))
    else $error("sequence pointer did not advance");
  a_short_entry: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    trig_rise[2] |=> start_cmd_q.src == SRC_SHORTCUT &&
    start_cmd_q.entry == $past(map_q[0]))
    else $error("shortcut entry wrong");
  a_one_start: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    trig_rise[0] |=> !trig_rise[0])
    else $error("held trigger repeated");
  a_sel_order: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    $stable(sel_s1_q) |=> sel_q == $past(sel_s1_q))
    else $error("select path broken");
  a_map_reset: assert property (
    @(posedge sys_clk)
    $rose(rst_b) |-> map_q[5] == 6'h05)
    else $error("map default wrong");
  a_seq_entry: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (trig_rise[1] && !trig_rise[0] && !(|trig_rise[7:2])) |=>
    start_cmd_q.src == SRC_SEQ && start_cmd_q.entry == $past(seq_ptr_q))
    else $error("sequential start entry wrong");
  a_short_map1: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (trig_rise[3] && !trig_rise[2]) |=> start_cmd_q.src == SRC_SHORTCUT &&
    start_cmd_q.entry == $past(map_q[1]))
    else $error("shortcut one entry wrong");
  a_short_map5: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (trig_rise[7] && !(|trig_rise[6:2])) |=>
    start_cmd_q.entry == $past(map_q[5]))
    else $error("shortcut five entry wrong");
  a_start_cause: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    start_cmd_q.valid |-> $past(|trig_rise))
    else $error("start without trigger edge");
  a_alarm_start: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    $rose(home_alarm_q) |-> start_cmd_q.valid)
    else $error("alarm raised without a start");
  a_alarm_clear: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    origin_ok |=> !home_alarm_q)
    else $error("alarm kept with origin known");
  a_alarm_enable: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (wr_en && paddr == CTRL_OFF) |=>
    alm_en_q == $past(pwdata[CTRL_ALM_EN_BIT]))
    else $error("alarm enable not written");
  a_map_write: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (wr_en && paddr == MAP_HI_OFF) |=> map_q[5] == $past(pwdata[13:8]))
    else $error("shortcut map not written");
  a_irq_sticky: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    irq_set[0] |=> irq_stat_q[0])
    else $error("start status bit not set");
  a_irq_level: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (|(irq_stat_q & irq_mask_q)) |=> irq_q)
    else $error("interrupt not raised");
  a_apb_ready: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (psel && !penable) |=> pready)
    else $error("bus answer missing");
  a_apb_error: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (psel && !penable && !hit) |=> pslverr)
    else $error("unmapped access not flagged");

  // ----------------------------------------------------------------------
  // coverage of the main scenarios
  // ----------------------------------------------------------------------
  c_plain: cover property (@(posedge sys_clk) start_cmd_q.src == SRC_PLAIN
    && start_cmd_q.valid);
  c_seq: cover property (@(posedge sys_clk) start_cmd_q.src == SRC_SEQ
    && start_cmd_q.valid);
  c_short: cover property (@(posedge sys_clk) start_cmd_q.valid
    && start_cmd_q.src == SRC_SHORTCUT);
  c_alarm: cover property (@(posedge sys_clk) $rose(home_alarm_q));
  c_irq: cover property (@(posedge sys_clk) $rose(irq_q));

endmodule : oss_top

// [verif/oss_host_model.sv]
`timescale 1ns/1ps
// --------------------------------------------------------------------
// host side: drives select, trigger and origin levels
// --------------------------------------------------------------------
module oss_host_model (
  output logic [5:0] sel_q,    // data select levels
  output logic [7:0] trig_q,   // 0..5 shortcut, 6 plain, 7 sequential
  output logic       origin_q, // position origin known
  input  wire logic  sys_clk   // clock
);
  initial begin
    sel_q    = 6'h00;
    trig_q   = 8'h00;
    origin_q = 1'b0;
  end

  // selects settle well before the trigger edge
  task automatic set_sel(input logic [5:0] e);
    @(posedge sys_clk);
    sel_q <= e;
    repeat (3) @(posedge sys_clk);
  endtask : set_sel

  // hold the trigger, then stay low long enough to re-arm
  task automatic trig(input int idx, input int hold);
    @(posedge sys_clk);
    trig_q[idx] <= 1'b1;
    repeat (hold) @(posedge sys_clk);
    trig_q[idx] <= 1'b0;
    repeat (8) @(posedge sys_clk);
  endtask : trig

  task automatic set_origin(input logic v);
    @(posedge sys_clk);
    origin_q <= v;
    repeat (4) @(posedge sys_clk);
  endtask : set_origin
endmodule : oss_host_model

// [verif/tb_oss_top.sv]
`timescale 1ns/1ps
module tb_oss_top;
  import oss_pkg::*;
  logic          sys_clk, rst_b, psel, penable, pwrite, pready, pslverr;
  logic          err, home_alarm_q, irq_q, origin;
  logic [7:0]    paddr, trig;
  logic [31:0]   pwdata, prdata, rd;
  logic [5:0]    sel;
  oss_start_type start_cmd_q, last_start;
  int            num_errors, num_checks, n_starts, exp_n;
  logic [5:0]    pl[9] = '{6'h00, 6'h01, 6'h02, 6'h04, 6'h08, 6'h10,
                           6'h20, 6'h3f, 6'h2a};
  logic [5:0]    mp[6] = '{6'h09, 6'h15, 6'h2a, 6'h3f, 6'h33, 6'h1e};

  oss_top u_dut (
    .sys_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr,
    .data_select_bit0(sel[0]), .data_select_bit1(sel[1]),
    .data_select_bit2(sel[2]), .data_select_bit3(sel[3]),
    .data_select_bit4(sel[4]), .data_select_bit5(sel[5]),
    .start_trigger(trig[6]), .sequential_advance_trigger(trig[7]),
    .shortcut_trigger_0(trig[0]), .shortcut_trigger_1(trig[1]),
    .shortcut_trigger_2(trig[2]), .shortcut_trigger_3(trig[3]),
    .shortcut_trigger_4(trig[4]), .shortcut_trigger_5(trig[5]),
    .origin_set(origin), .start_cmd_q, .home_alarm_q, .irq_q
  );

  oss_host_model u_host (
    .sel_q(sel), .trig_q(trig), .origin_q(origin), .sys_clk
  );

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // count start pulses and keep the last one
  always @(posedge sys_clk) begin
    if (start_cmd_q.valid === 1'b1) begin
      n_starts++;
      last_start = start_cmd_q;
    end
  end

  // --------------------------------------------------------------------
  // checking and bus tasks
  // --------------------------------------------------------------------
  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      num_errors++;
      complete_run();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic chk_start(input logic [2:0] src, input logic [5:0] e);
    exp_n++;
    chk(n_starts, exp_n);
    chk(last_start.src, src);
    chk(last_start.entry, e);
  endtask : chk_start

  // --------------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    num_errors = 0;
    num_checks = 0;
    n_starts = 0;
    exp_n = 0;
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    apb(1'b0, MAP_LO_OFF, 32'h0);
    chk(rd & 32'h3f3f3f3f, 32'h03020100);
    apb(1'b0, MAP_HI_OFF, 32'h0);
    chk(rd & 32'h3f3f3f3f, 32'h00000504);
    apb(1'b0, CTRL_OFF, 32'h0);
    chk(rd[0], ALM_EN_RST);
    apb(1'b0, 8'h1c, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    foreach (pl[i]) begin
      u_host.set_sel(pl[i]);
      u_host.trig(6, 2);
      chk_start(SRC_PLAIN, pl[i]);
    end
    chk(home_alarm_q, 1'b0);
    u_host.trig(7, 2);
    chk_start(SRC_SEQ, 6'h2b);
    u_host.trig(7, 2);
    chk_start(SRC_SEQ, 6'h2c);
    u_host.set_sel(6'h3f);
    u_host.trig(6, 2);
    chk_start(SRC_PLAIN, 6'h3f);
    u_host.trig(7, 2);
    chk_start(SRC_SEQ, 6'h00);
    u_host.trig(6, 30);
    chk_start(SRC_PLAIN, 6'h3f);
    for (int i = 0; i < 6; i++) begin
      u_host.trig(i, 2);
      chk_start(SRC_SHORTCUT, 6'(i));
    end
    apb(1'b1, MAP_LO_OFF, 32'h3f2a1509);
    apb(1'b1, MAP_HI_OFF, 32'h00001e33);
    for (int i = 0; i < 6; i++) begin
      u_host.trig(i, 2);
      chk_start(SRC_SHORTCUT, mp[i]);
    end
    // interrupt: a set mask bit lets status through, then cleared
    chk(irq_q, 1'b0);
    apb(1'b1, IRQ_MASK_OFF, 32'h3);
    repeat (2) @(posedge sys_clk);
    chk(irq_q, 1'b1);
    apb(1'b1, IRQ_STAT_OFF, 32'h3);
    apb(1'b0, IRQ_STAT_OFF, 32'h0);
    chk(rd[1:0], 2'h0);
    chk(irq_q, 1'b0);
    apb(1'b1, IRQ_MASK_OFF, 32'h2);
    // alarm enabled, no origin yet
    apb(1'b1, CTRL_OFF, 32'h1);
    u_host.trig(6, 2);
    chk_start(SRC_PLAIN, 6'h3f);
    chk(home_alarm_q, 1'b1);
    apb(1'b0, IRQ_STAT_OFF, 32'h0);
    chk(rd[1:0], 2'h3);
    chk(irq_q, 1'b1);
    u_host.set_origin(1'b1);
    chk(home_alarm_q, 1'b0);
    u_host.trig(7, 2);
    chk_start(SRC_SEQ, 6'h00);
    chk(home_alarm_q, 1'b0);
    u_host.set_origin(1'b0);
    u_host.trig(0, 2);
    chk_start(SRC_SHORTCUT, mp[0]);
    chk(home_alarm_q, 1'b1);
    apb(1'b0, LAST_OFF, 32'h0);
    chk(rd, {26'h0, mp[0]});
    apb(1'b0, STATUS_OFF, 32'h0);
    chk(rd, 32'h000280fd);
    apb(1'b1, CTRL_OFF, 32'h3);
    apb(1'b0, CTRL_OFF, 32'h0);
    chk(rd, 32'h3);
    chk(home_alarm_q, 1'b0);
    apb(1'b1, CTRL_OFF, 32'h5);
    apb(1'b0, CTRL_OFF, 32'h0);
    chk(rd, 32'h1);
    complete_run();
  end
endmodule : tb_oss_top
